// ==== core/lsp_consts.vh ====
`ifndef LSP_CONSTS_VH
`define LSP_CONSTS_VH
`define LSP_IDX_MAINT 8'h71
`define LSP_IDX_CFG 8'h76
`define LSP_IDX_SAFE 8'h78
`define LSP_IDX_RETRY 8'h7a
`define LSP_IDX_STATUS 8'h7c
`define LSP_RST_CFG 16'h0001
`define LSP_RST_SAFE 32'h00000000
`define LSP_RST_RETRY 16'h0000
`define LSP_CMD_RESET 16'hfffa
`define LSP_CMD_FACTORY 16'hfffb
`define LSP_CMD_USER 16'hfffc
`define LSP_LOSS_LSB 0
`define LSP_PWR_LSB 2
`define LSP_WAIT1_S 16'h000f
`define LSP_WAIT2_S 16'h001e
`define LSP_WAIT3_S 16'h003c
`define LSP_CLK_HZ 50000000
`endif

// ==== core/lsp_ctrl.v ====
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`include "lsp_consts.vh"
module lsp_ctrl #(
    parameter CLK_PER_SEC = `LSP_CLK_HZ // cycles per second tick
) (
    input wire clock, // system clock
    input wire rst_b, // async reset, active low
    input wire [9:0] avs_address, // byte address
    input wire avs_read, // read request
    input wire avs_write, // write request
    input wire [31:0] avs_writedata, // write data
    input wire [3:0] avs_byteenable, // byte lanes
    output reg [31:0] avs_readdata, // read data
    output wire avs_waitrequest, // stall
    input wire link_up, // connection established level
    input wire [15:0] ctrl_word, // cyclic control word
    input wire [31:0] host_target, // host target position
    input wire host_run, // host run request pulse
    input wire run_done, // motion finished ok pulse
    input wire run_fail, // motion failed pulse
    input wire [15:0] mid_position, // middle of range (low bits)
    output reg [31:0] motion_target, // target handed to motion
    output reg motion_start, // start pulse
    output reg motion_abort, // abort pulse
    output reg sys_reset_req, // full reset request pulse
    output reg factory_load, // load factory values pulse
    output reg user_load, // reload saved values pulse
    output reg nv_store, // store to nonvolatile pulse
    output reg keep_net_addr // address params protected
);
    // the sequencer owns the motion interface; every output pulse is
    // registered, so the motion side never sees a combinational glitch
    // state codes
    localparam ST_IDLE = 3'd0;
    localparam ST_HOST = 3'd1;
    localparam ST_MID = 3'd2;
    localparam ST_SAFE = 3'd3;
    localparam ST_WAITR = 3'd4;
    reg [2:0] state_reg; // current mode
    reg [15:0] cfg_reg; // timeout configuration
    reg [31:0] safe_reg; // safe target position
    reg [15:0] retry_reg; // retry seconds
    reg [15:0] maint_reg; // last maintenance value
    reg [31:0] div_reg; // cycle divider
    reg sec_tick; // one second enable
    reg [15:0] sec_reg; // second counter
    reg was_up_reg; // link ever established
    reg link_d_reg; // link level last cycle
    reg pwr_done_reg; // power-up wait finished
    reg [15:0] ctrl_d_reg; // control word at centering start
    reg ack_reg; // bus answer phase
    wire [7:0] idx = avs_address[9:2]; // word index
    // a write lands only at the edge where waitrequest is seen low, so a
    // master that gives up early never leaves half a command behind
    wire wr = avs_write & ack_reg; // one write per request
    wire [1:0] loss_code = cfg_reg[`LSP_LOSS_LSB+1:`LSP_LOSS_LSB]; // loss reaction
    wire [1:0] pwr_code = cfg_reg[`LSP_PWR_LSB+1:`LSP_PWR_LSB]; // power-up code
    wire link_lost = link_d_reg & ~link_up & was_up_reg; // loss event
    reg [15:0] pwr_wait; // seconds to wait at power-up

    // one wait state per access keeps answers registered
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;

    // codes other than one to three leave the wait at zero, but the
    // sequencer also tests the code itself, so zero never starts a run
    // power-up wait selection
    always @*
    begin
        case (pwr_code)
            2'd1: pwr_wait = `LSP_WAIT1_S;
            2'd2: pwr_wait = `LSP_WAIT2_S;
            2'd3: pwr_wait = `LSP_WAIT3_S;
            default: pwr_wait = 16'h0000;
        endcase
    end

    // a single free-running divider serves both the power-up wait and the
    // retry interval; timing is therefore only good to one second
    // second tick divider
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            div_reg <= 32'h00000000;
            sec_tick <= 1'b0;
        end
        else if (div_reg == CLK_PER_SEC - 1)
        begin
            div_reg <= 32'h00000000;
            sec_tick <= 1'b1;
        end
        else
        begin
            div_reg <= div_reg + 32'h00000001;
            sec_tick <= 1'b0;
        end
    end

    // bus answer and readback
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ack_reg <= 1'b0;
            avs_readdata <= 32'h00000000;
        end
        else
        begin
            ack_reg <= (avs_read | avs_write) & ~ack_reg;
            if (avs_read & ~ack_reg)
            begin
                case (idx)
                    `LSP_IDX_MAINT: avs_readdata <= {16'h0000, maint_reg};
                    `LSP_IDX_CFG: avs_readdata <= {16'h0000, cfg_reg};
                    `LSP_IDX_SAFE: avs_readdata <= safe_reg;
                    `LSP_IDX_RETRY: avs_readdata <= {16'h0000, retry_reg};
                    `LSP_IDX_STATUS: avs_readdata <= {24'h000000, pwr_done_reg,
                        was_up_reg, link_up, 2'b00, state_reg};
                    // unmapped reads as zero
                    default: avs_readdata <= 32'h00000000;
                endcase
            end
        end
    end

    // configuration registers with byte lanes
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cfg_reg <= `LSP_RST_CFG;
            safe_reg <= `LSP_RST_SAFE;
            retry_reg <= `LSP_RST_RETRY;
        end
        else if (wr)
        begin
            if (idx == `LSP_IDX_CFG)
            begin
                if (avs_byteenable[0]) cfg_reg[7:0] <= avs_writedata[7:0];
                if (avs_byteenable[1]) cfg_reg[15:8] <= avs_writedata[15:8];
            end
            if (idx == `LSP_IDX_SAFE)
            begin
                if (avs_byteenable[0]) safe_reg[7:0] <= avs_writedata[7:0];
                if (avs_byteenable[1]) safe_reg[15:8] <= avs_writedata[15:8];
                if (avs_byteenable[2]) safe_reg[23:16] <= avs_writedata[23:16];
                if (avs_byteenable[3]) safe_reg[31:24] <= avs_writedata[31:24];
            end
            if (idx == `LSP_IDX_RETRY)
            begin
                if (avs_byteenable[0]) retry_reg[7:0] <= avs_writedata[7:0];
                if (avs_byteenable[1]) retry_reg[15:8] <= avs_writedata[15:8];
            end
        end
    end

    // maintenance writes win over link events, and link events over the
    // power-up timer, so one cycle never starts two runs
    // supervisory sequencer
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_reg <= ST_IDLE;
            maint_reg <= 16'h0000;
            sec_reg <= 16'h0000;
            was_up_reg <= 1'b0;
            link_d_reg <= 1'b0;
            pwr_done_reg <= 1'b0;
            ctrl_d_reg <= 16'h0000;
            motion_target <= 32'h00000000;
            motion_start <= 1'b0;
            motion_abort <= 1'b0;
            sys_reset_req <= 1'b0;
            factory_load <= 1'b0;
            user_load <= 1'b0;
            nv_store <= 1'b0;
            keep_net_addr <= 1'b0;
        end
        else
        begin
            motion_start <= 1'b0;
            motion_abort <= 1'b0;
            sys_reset_req <= 1'b0;
            factory_load <= 1'b0;
            user_load <= 1'b0;
            nv_store <= 1'b0;
            keep_net_addr <= 1'b0;
            link_d_reg <= link_up;
            if (link_up)
                was_up_reg <= 1'b1;
            if (sec_tick)
                sec_reg <= sec_reg + 16'h0001;
            if (wr && avs_byteenable[0] && idx == `LSP_IDX_MAINT)
            begin
                maint_reg <= avs_writedata[15:0];
                if (avs_writedata[15:0] == `LSP_CMD_RESET)
                    sys_reset_req <= 1'b1;
                if (avs_writedata[15:0] == `LSP_CMD_FACTORY)
                begin
                    factory_load <= 1'b1;
                    nv_store <= 1'b1;
                    keep_net_addr <= 1'b1;
                end
                if (avs_writedata[15:0] == `LSP_CMD_USER)
                    user_load <= 1'b1;
                if (avs_writedata[15:0] == `LSP_CMD_FACTORY ||
                    avs_writedata[15:0] == `LSP_CMD_USER)
                begin
                    state_reg <= ST_MID;
                    ctrl_d_reg <= ctrl_word;
                    motion_target <= {16'h0000, mid_position};
                    motion_start <= 1'b1;
                end
            end
            else if (link_lost && state_reg != ST_MID)
            begin
                if (loss_code == 2'd1)
                begin
                    // abort positioning; code three does nothing
                    motion_abort <= 1'b1;
                    state_reg <= ST_IDLE;
                end
                else if (loss_code == 2'd2)
                begin
                    motion_target <= safe_reg;
                    motion_start <= 1'b1;
                    state_reg <= ST_SAFE;
                end
            end
            else if (!pwr_done_reg && !was_up_reg && pwr_code != 2'd0 &&
                     sec_reg >= pwr_wait)
            begin
                pwr_done_reg <= 1'b1;
                motion_target <= safe_reg;
                motion_start <= 1'b1;
                state_reg <= ST_SAFE;
            end
            else
            begin
                case (state_reg)
                    ST_IDLE:
                    begin
                        if (host_run && link_up)
                        begin
                            motion_target <= host_target;
                            motion_start <= 1'b1;
                            state_reg <= ST_HOST;
                        end
                    end
                    ST_HOST:
                    begin
                        if (run_done || run_fail)
                            state_reg <= ST_IDLE;
                    end
                    ST_MID:
                    begin
                        // only a control word change aborts
                        if (ctrl_word != ctrl_d_reg)
                        begin
                            motion_abort <= 1'b1;
                            state_reg <= ST_IDLE;
                        end
                        // back to idle, old command dropped
                        else if (run_done || run_fail)
                            state_reg <= ST_IDLE;
                    end
                    ST_SAFE:
                    begin
                        if (run_done)
                            state_reg <= ST_IDLE;
                        else if (run_fail)
                        begin
                            sec_reg <= 16'h0000;
                            state_reg <= (retry_reg == 16'h0000) ? ST_IDLE : ST_WAITR;
                        end
                    end
                    ST_WAITR:
                    begin
                        if (sec_reg >= retry_reg)
                        begin
                            motion_target <= safe_reg;
                            motion_start <= 1'b1;
                            state_reg <= ST_SAFE;
                        end
                    end
                    default: state_reg <= ST_IDLE;
                endcase
            end
        end
    end
endmodule

// ==== test/lsp_ctrl_sva.sv ====
`timescale 1ns/1ns
// port-level checker for the supervisory block
module lsp_ctrl_sva (
    input wire clock, // system clock
    input wire rst_b, // async reset, low
    input wire [9:0] avs_address, // byte address
    input wire avs_write, // write request
    input wire avs_waitrequest, // stall
    input wire [31:0] avs_writedata, // write data
    input wire [3:0] avs_byteenable, // byte lanes
    input wire link_up, // link level
    input wire [15:0] ctrl_word, // control word
    input wire [15:0] mid_position, // middle of range
    input wire run_done, // run ok
    input wire run_fail, // run failed
    input wire [31:0] motion_target, // target out
    input wire motion_start, // start pulse
    input wire motion_abort, // abort pulse
    input wire sys_reset_req, // reset pulse
    input wire factory_load, // factory pulse
    input wire user_load, // reload pulse
    input wire nv_store, // store pulse
    input wire keep_net_addr // address kept
);
    reg [1:0] loss_reg; // mirror of the loss code field
    reg mid_reg; // a centering run is under way
    // first cycle of a maintenance write only, so each command fires once
    wire mw = avs_write && avs_waitrequest && avs_byteenable[0] && avs_address == 10'h1c4;
    wire [15:0] cmd = avs_writedata[15:0]; // command value
    // mirrors track writes and centering
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            loss_reg <= 2'h1;
            mid_reg <= 1'b0;
        end
        else
        begin
            if (avs_write && avs_address == 10'h1d8 && avs_byteenable[0])
                loss_reg <= avs_writedata[1:0];
            if (factory_load || user_load)
                mid_reg <= 1'b1;
            else if (motion_abort || run_done || run_fail)
                mid_reg <= 1'b0;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    a_reset_cmd: assert property (mw && cmd == 16'hfffa |-> ##[1:3] sys_reset_req)
        else $error("reset command gave no request");
    a_factory_cmd: assert property (mw && cmd == 16'hfffb |-> ##[1:3] (factory_load && nv_store))
        else $error("factory command gave no load and store");
    a_keep_addr: assert property (factory_load |-> keep_net_addr)
        else $error("factory load without address protection");
    a_user_cmd: assert property (mw && cmd == 16'hfffc |-> ##[1:3] user_load)
        else $error("user command gave no reload");
    a_center_run: assert property ((factory_load || user_load) |->
        motion_start && motion_target == {16'h0, mid_position})
        else $error("reload not followed by centering run");
    a_center_abort: assert property (mid_reg && $changed(ctrl_word) |-> ##[0:2] motion_abort)
        else $error("control word change did not abort centering");
    a_loss_keep: assert property ($fell(link_up) && !mid_reg && loss_reg == 2'h0 |->
        !motion_abort [*4])
        else $error("loss code zero aborted the run");
    a_loss_abort: assert property ($fell(link_up) && !mid_reg && loss_reg == 2'h1 |->
        ##[0:2] motion_abort)
        else $error("loss code one did not abort");
    a_loss_safe: assert property ($fell(link_up) && !mid_reg && loss_reg == 2'h2 |->
        ##[0:2] motion_start)
        else $error("loss code two did not start safe run");
endmodule
bind lsp_ctrl lsp_ctrl_sva lsp_ctrl_sva_inst (.clock, .rst_b, .avs_address, .avs_write,
    .avs_waitrequest, .avs_writedata, .avs_byteenable, .link_up, .ctrl_word, .mid_position,
    .run_done, .run_fail, .motion_target, .motion_start, .motion_abort, .sys_reset_req,
    .factory_load, .user_load, .nv_store, .keep_net_addr);

// ==== test/lsp_fb_model.sv ====
`timescale 1ns/1ns
// cyclic fieldbus controller: link level, control word and host target
module lsp_fb_model (
    input wire clock, // system clock
    output logic link_up, // connection level
    output logic [15:0] ctrl_word, // cyclic control word
    output logic [31:0] host_target, // host target
    output logic host_run // run request pulse
);
    initial
    begin
        link_up = 1'b0;
        ctrl_word = 16'h0;
        host_target = 32'h0;
        host_run = 1'b0;
    end
    // each exchange cycle carries a fresh target so stale data never hides
    always @(posedge clock)
        host_target <= host_target + 32'h9e37;
    task link(input logic up);
        @(posedge clock);
        link_up <= up;
    endtask
    // one-cycle host run request
    task run;
        @(posedge clock);
        host_run <= 1'b1;
        @(posedge clock);
        host_run <= 1'b0;
    endtask
    task ctrl(input logic [15:0] w);
        @(posedge clock);
        ctrl_word <= w;
    endtask
endmodule

// ==== test/lsp_ctrl_bench.sv ====
`timescale 1ns/1ns
// bench: bus master, motion side and pulse bookkeeping
module lsp_ctrl_bench;
    logic clock = 1'b0; // system clock
    logic rst_b = 1'b0; // reset, low
    logic [9:0] avs_address = 10'h0; // bus address
    logic avs_read = 1'b0; // read request
    logic avs_write = 1'b0; // write request
    logic [31:0] avs_writedata = 32'h0; // write data
    logic [3:0] avs_byteenable = 4'hf; // all lanes
    logic run_done = 1'b0; // motion ok
    logic run_fail = 1'b0; // motion failed
    logic [15:0] mid_position = 16'h0; // middle of range
    wire [31:0] avs_readdata, motion_target, host_target; // wide outputs
    wire avs_waitrequest, link_up, host_run, motion_start, motion_abort; // flags
    wire sys_reset_req, factory_load, user_load, nv_store, keep_net_addr; // pulses
    wire [15:0] ctrl_word; // control word
    int miscompares = 0; // mismatches
    int tests_run = 0; // comparisons
    int cnt [7]; // pulses seen per kind
    int ecnt [7]; // pulses expected per kind
    logic [31:0] seen_target; // target at last start
    logic [31:0] host_seen; // host target at last run request
    logic [31:0] lfsr = 32'he4b4; // random source
    logic [31:0] q; // last read data
    logic [31:0] safe; // chosen safe position
    logic [31:0] mdl [int]; // register model by address
    wire [6:0] ev = {keep_net_addr, nv_store, user_load, factory_load, sys_reset_req,
        motion_abort, motion_start}; // pulse kinds
    lsp_fb_model fb (.clock, .link_up, .ctrl_word, .host_target, .host_run);
    lsp_ctrl #(.CLK_PER_SEC(10)) lsp_ctrl_inst (.clock, .rst_b, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .link_up, .ctrl_word, .host_target, .host_run, .run_done, .run_fail, .mid_position,
        .motion_target, .motion_start, .motion_abort, .sys_reset_req, .factory_load,
        .user_load, .nv_store, .keep_net_addr);
    always #10 clock = ~clock;
    // count every one-cycle pulse, since each stands for one cycle only
    always @(posedge clock)
    begin
        for (int i = 0; i < 7; i++)
            if (ev[i] === 1'b1)
                cnt[i] <= cnt[i] + 1;
        if (motion_start === 1'b1)
            seen_target <= motion_target;
        if (host_run === 1'b1)
            host_seen <= host_target;
    end
    function logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task check(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e)
        begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // one transfer held until waitrequest is seen low
    task bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    // 16-bit registers keep only their low half
    task wreg(input logic [9:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
        if (a != 10'h1c4)
            mdl[a] = (a == 10'h1e0) ? d : {16'h0, d[15:0]};
    endtask
    task rreg(input logic [9:0] a);
        bus(1'b0, a, 32'h0);
        check(q, mdl.exists(a) ? mdl[a] : 32'h0);
    endtask
    task settle(input int n);
        repeat (n) @(posedge clock);
        for (int i = 0; i < 7; i++)
            check(cnt[i], ecnt[i]);
    endtask
    task pulse(input logic fail);
        if (fail) run_fail <= 1'b1; else run_done <= 1'b1;
        @(posedge clock);
        run_fail <= 1'b0;
        run_done <= 1'b0;
    endtask
    task conclude;
        $display("Counts: %0d compares, %0d errors", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // cut a hang short well beyond the expected run
    initial
    begin
        repeat (5000) @(posedge clock);
        miscompares++;
        conclude;
    end
    initial
    begin
        mdl[10'h1d8] = 32'h1;
        mdl[10'h1e0] = 32'h0;
        mdl[10'h1e8] = 32'h0;
        mid_position <= lfsr[15:0];
        repeat (20) @(posedge clock);
        rst_b <= 1'b1;
        rreg(10'h1d8);
        rreg(10'h1e0);
        rreg(10'h1e8);
        rreg(10'h3fc);
        lfsr = nxt(lfsr);
        safe = lfsr;
        wreg(10'h1e0, safe);
        wreg(10'h1e8, 32'h2);
        wreg(10'h1d8, 32'h4);
        rreg(10'h1e0);
        settle(110);
        ecnt[0] = 1;
        settle(40);
        check(seen_target, safe);
        pulse(1'b1);
        settle(8);
        ecnt[0] = 2;
        settle(20);
        wreg(10'h1e8, 32'h0);
        pulse(1'b1);
        settle(60);
        // loss codes zero to two in turn, with the link first brought up
        for (int c = 0; c < 3; c++)
        begin
            wreg(10'h1d8, c);
            fb.link(1'b1);
            settle(5);
            fb.link(1'b0);
            ecnt[0] += (c == 2);
            ecnt[1] += (c == 1);
            settle(6);
        end
        check(seen_target, safe);
        pulse(1'b0);
        fb.link(1'b1);
        fb.ctrl(16'h0014);
        wreg(10'h1c4, 32'hfffb);
        ecnt[0]++;
        ecnt[3]++;
        ecnt[5]++;
        ecnt[6]++;
        settle(4);
        check(seen_target, {16'h0, mid_position});
        fb.ctrl(16'h0015);
        ecnt[1]++;
        settle(4);
        fb.ctrl(16'h0014);
        // a host run that the centering run must not bring back later
        fb.run;
        ecnt[0]++;
        settle(3);
        check(seen_target, host_seen);
        wreg(10'h1c4, 32'hfffc);
        ecnt[0]++;
        ecnt[4]++;
        settle(20);
        pulse(1'b0);
        settle(20);
        // a maintenance write without the low byte lane is refused
        avs_byteenable <= 4'he;
        wreg(10'h1c4, 32'hfffa);
        settle(4);
        avs_byteenable <= 4'hf;
        wreg(10'h1c4, 32'hfffa);
        ecnt[2]++;
        settle(4);
        conclude;
    end
endmodule
